/* File: ces_pkg.sv */
/*
  Types shared by the cipher engine status block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ces_pkg;

  typedef enum logic [2:0] {
    CES_MODE_NORMAL = 3'h0,
    CES_MODE_PREBOOT = 3'h1,
    CES_MODE_KEY_WRAP = 3'h2,
    CES_MODE_CONTENT_KEY = 3'h3
  } ces_mode_t;

  typedef enum logic [2:0] {
    CES_OP_ENCRYPT = 3'h1,
    CES_OP_DECRYPT = 3'h2,
    CES_OP_AUTH = 3'h4
  } ces_op_t;

  typedef enum logic [1:0] {
    CES_PH_DESC = 2'h0,
    CES_PH_SEC_ASSOC = 2'h1,
    CES_PH_SRC = 2'h2,
    CES_PH_DST = 2'h3
  } ces_phase_t;

  typedef enum logic [3:0] {
    CES_ST_IDLE = 4'h0,
    CES_ST_FETCH_PEND = 4'h1,
    CES_ST_LOADING = 4'h2,
    CES_ST_DATA = 4'h3,
    CES_ST_DONE = 4'h4,
    CES_ST_FETCH_OFF = 4'h5,
    CES_ST_SA_FETCH = 4'h6
  } ces_state_t;

  // Error context reported by the engine datapath.
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] op;
    logic [1:0] phase;
  } ces_err_t;

  // Descriptor processor view driven by the engine sequencer.
  typedef struct packed {
    logic [3:0] state;
    logic active;
    logic [15:0] ctrl;
  } ces_desc_t;

endpackage : ces_pkg

/* File: ces_regs.svh */
/*
  Register offsets, field positions and reset values of the cipher engine
  status block. Assumes inclusion by bare name from the package or module.
*/
`ifndef CES_REGS_SVH
`define CES_REGS_SVH

`define CES_OFF_STATUS 12'h000
`define CES_OFF_IRQ_STAT 12'h004
`define CES_OFF_IRQ_MASK 12'h008
`define CES_ADDR_W 12

`define CES_MODE_HI 31
`define CES_MODE_LO 29
`define CES_OP_HI 28
`define CES_OP_LO 26
`define CES_PHASE_HI 25
`define CES_PHASE_LO 24
`define CES_RSVD_HI 23
`define CES_RSVD_LO 22
`define CES_STATE_HI 21
`define CES_STATE_LO 18
`define CES_START_BIT 17
`define CES_ACTIVE_BIT 16
`define CES_CTRL_HI 15
`define CES_CTRL_LO 0

`define CES_STATUS_RESET 32'h0000_0000
`define CES_IRQ_RESET 4'h0
`define CES_IRQ_W 4

`define CES_RESP_OKAY 2'h0
`define CES_RESP_SLVERR 2'h2

`endif

/* File: ces_status.sv */
/*
  AXI4-Lite slave holding the read-only cipher engine status register plus a
  small sticky event/mask interrupt pair. Assumes engine inputs synchronous
  to aclk and a master that keeps AXI4-Lite valid/ready rules.
*/
`timescale 1ns/1ps
`include "ces_regs.svh"

// Notes on behaviour
// - Bits 31-29 report error context mode.
// - Bits 28-26 report failed operation.
// - Bits 25-24 report failing DMA phase.
// - Bits 21-18 report descriptor processor state.
// - Bit 17 set once DMA start occurred.
// - Read-only, resets zero, bits 23-22 zero.
module ces_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [`CES_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CES_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ces_pkg::ces_err_t eng_err,
  input wire logic eng_err_valid,
  input wire logic dma_start,
  input wire ces_pkg::ces_desc_t eng_desc,
  output logic irq
);
  import ces_pkg::*;

  // Engine status captured into flops so the read path sees stable values.
  ces_err_t err_q;
  ces_err_t err_d;
  ces_desc_t desc_q;
  logic start_q;
  logic done_seen_q;
  logic [`CES_IRQ_W-1:0] irq_stat_q;
  logic [`CES_IRQ_W-1:0] irq_stat_d;
  logic [`CES_IRQ_W-1:0] irq_mask_q;
  logic irq_q;

  logic aw_have_q;
  logic w_have_q;
  logic [`CES_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // Error capture: a reported error latches its context.
  assign err_d = eng_err_valid ? eng_err : err_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= '0;
      desc_q <= '0;
      start_q <= 1'b0;
      done_seen_q <= 1'b0;
    end else if (clk_en) begin
      err_q <= err_d;
      desc_q <= eng_desc;
      done_seen_q <= (eng_desc.state == CES_ST_DONE);
      if (dma_start) begin
        start_q <= 1'b1;
      end
    end
  end

  // Status word assembly; unimplemented bits are forced to zero.
  logic [31:0] status_word;
  always_comb begin
    status_word = `CES_STATUS_RESET;
    status_word[`CES_MODE_HI:`CES_MODE_LO] = err_q.mode;
    status_word[`CES_OP_HI:`CES_OP_LO] = err_q.op;
    status_word[`CES_PHASE_HI:`CES_PHASE_LO] = err_q.phase;
    status_word[`CES_RSVD_HI:`CES_RSVD_LO] = 2'h0;
    status_word[`CES_STATE_HI:`CES_STATE_LO] = desc_q.state;
    status_word[`CES_START_BIT] = start_q;
    status_word[`CES_ACTIVE_BIT] = desc_q.active;
    status_word[`CES_CTRL_HI:`CES_CTRL_LO] = desc_q.ctrl;
  end

  // Events: bit0 error, bit1 DMA start, bit2 descriptor done entry,
  // bit3 processor went idle from active.
  wire done_rise = (eng_desc.state == CES_ST_DONE) && !done_seen_q;
  wire idle_fall = desc_q.active && !eng_desc.active;
  wire [`CES_IRQ_W-1:0] irq_events = {idle_fall, done_rise, dma_start,
                                      eng_err_valid};

  // Write channel: address and data may arrive in either order.
  wire aw_take = s_axi_awvalid && !aw_have_q && !bvalid_q;
  wire w_take = s_axi_wvalid && !w_have_q && !bvalid_q;
  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  // Byte lane bits are ignored, so only whole words are decoded.
  wire [`CES_ADDR_W-1:0] aw_word = {aw_addr_q[`CES_ADDR_W-1:2], 2'b00};
  wire wr_stat = wr_go && (aw_word == `CES_OFF_IRQ_STAT);
  wire wr_mask = wr_go && (aw_word == `CES_OFF_IRQ_MASK);
  wire wr_ro = wr_go && (aw_word == `CES_OFF_STATUS);
  wire [1:0] wr_resp = (wr_stat || wr_mask || wr_ro) ? `CES_RESP_OKAY :
                       `CES_RESP_SLVERR;

  // Set wins over write-one-to-clear in the same cycle.
  wire [`CES_IRQ_W-1:0] w1c = (wr_stat && w_strb_q[0]) ?
                              w_data_q[`CES_IRQ_W-1:0] : '0;
  assign irq_stat_d = (irq_stat_q & ~w1c) | irq_events;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `CES_RESP_OKAY;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_resp;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= `CES_IRQ_RESET;
      irq_mask_q <= `CES_IRQ_RESET;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_stat_q <= irq_stat_d;
      if (wr_mask && w_strb_q[0]) begin
        irq_mask_q <= w_data_q[`CES_IRQ_W-1:0];
      end
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  // Read channel: one outstanding read, answered the cycle after arvalid.
  wire ar_take = s_axi_arvalid && !rvalid_q;
  wire [`CES_ADDR_W-1:0] ar_word = {s_axi_araddr[`CES_ADDR_W-1:2], 2'b00};
  wire rd_status = (ar_word == `CES_OFF_STATUS);
  wire rd_stat = (ar_word == `CES_OFF_IRQ_STAT);
  wire rd_mask = (ar_word == `CES_OFF_IRQ_MASK);
  wire [31:0] rd_word = rd_status ? status_word :
                        rd_stat ? {28'h000_0000, irq_stat_q} :
                        rd_mask ? {28'h000_0000, irq_mask_q} :
                        32'h0000_0000;
  wire [1:0] rd_resp = (rd_status || rd_stat || rd_mask) ? `CES_RESP_OKAY :
                       `CES_RESP_SLVERR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= `CES_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_resp;
        rdata_q <= rd_word;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Ready is combinational on purpose; gating by clk_en keeps frozen
  // cycles from completing AW, W and AR handshakes the state would not record.
  assign s_axi_awready = aw_take && clk_en;
  assign s_axi_wready = w_take && clk_en;
  assign s_axi_arready = ar_take && clk_en;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign irq = irq_q;

endmodule // ces_status

/* File: ces_status_checker.sv */
/* Assertions on the status block's read answers and fields.
   Assumes binding to ces_status, all logic in the aclk domain. */
`timescale 1ns/1ps
`include "ces_regs.svh"
module ces_checker
  import ces_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CES_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire ces_pkg::ces_err_t eng_err,
  input wire logic eng_err_valid,
  input wire logic dma_start,
  input wire ces_pkg::ces_desc_t eng_desc,
  input wire logic irq
);
  logic [`CES_ADDR_W-1:0] ra_q;
  logic st_rd;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra_q <= s_axi_araddr;
    end
  end
  assign st_rd = s_axi_rvalid && ra_q == 12'h000;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  gap_zero_a: assert property (st_rd |-> s_axi_rdata[23:22] == 2'h0)
    else $error("gap bits set");
  mode_code_a: assert property (st_rd |-> s_axi_rdata[31:29] < 3'h4)
    else $error("reserved mode code");
  op_code_a: assert property (st_rd |->
    s_axi_rdata[28:26] inside {3'h0, 3'h1, 3'h2, 3'h4})
    else $error("reserved op code");
  err_latch_a: assert property ($rose(s_axi_rvalid) && ra_q == 12'h000
    && $past(eng_err_valid, 2) |-> s_axi_rdata[31:24] == $past(eng_err, 2))
    else $error("error context not latched");
  desc_copy_a: assert property ($rose(s_axi_rvalid) && ra_q == 12'h000
    && $past(aresetn, 3) |->
    {s_axi_rdata[21:18], s_axi_rdata[16:0]} == $past(eng_desc, 2))
    else $error("descriptor view wrong");
  start_seen_a: assert property ($rose(s_axi_rvalid) && ra_q == 12'h000
    && $past(dma_start, 2) |-> s_axi_rdata[17])
    else $error("start bit missing");
  hole_err_a: assert property (s_axi_rvalid &&
    !(ra_q inside {12'h000, 12'h004, 12'h008}) |->
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read answered");
  reset_quiet_a: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_rvalid && !s_axi_bvalid && !irq)
    else $error("outputs live in reset");
  cover property ($rose(s_axi_rvalid) && ra_q == 12'h000);
  cover property (irq);
  cover property (s_axi_bvalid);
endmodule // ces_checker

bind ces_status ces_checker u_ces_checker (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_bvalid, .eng_err, .eng_err_valid, .dma_start, .eng_desc, .irq);

/* File: ces_status_tb.sv */
/* Self-checking bench for the cipher engine status block.
   Assumes the design and its checker are compiled alongside. */
`timescale 1ns/1ps
`include "ces_regs.svh"
module ces_status_tb;
  import ces_pkg::*;
  logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, eng_err_valid, dma_start, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  ces_err_t eng_err;
  ces_desc_t eng_desc;
  int n_errors = 0;
  int checks_done = 0;
  ces_status u_ces_status (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .eng_err,
    .eng_err_valid, .dma_start, .eng_desc, .irq);
  task automatic chk(input string w, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask
  // Readies are sampled at the falling edge, where they are settled.
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic h, v;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      h = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (h) s_axi_arvalid <= 1'b0;
    end while (!v);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ha, hw, v;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = s_axi_awready;
      hw = s_axi_wready;
      v = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!v);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk("read data", d, e);
  endtask
  task automatic t_err;
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      eng_err <= {i[2:0], 3'h1 << (i % 3), i[1:0]};
      eng_err_valid <= 1'b1;
      // Valid still stands as the read is issued, so the checker sees it.
      rchk(12'h000, {i[2:0], 3'h1 << (i % 3), i[1:0],
                     24'h00_0000});
      eng_err_valid <= 1'b0;
    end
  endtask
  task automatic t_desc;
    for (int i = 0; i < 7; i++) begin
      @(posedge aclk);
      eng_desc <= {i[3:0], 1'b1, 16'hA5C3 ^ i[15:0]};
      rchk(12'h000, {8'h67, 2'h0, i[3:0], 2'h1,
                     16'hA5C3 ^ i[15:0]});
    end
    eng_desc <= '0;
  endtask
  task automatic t_start;
    rchk(12'h000, 32'h6700_0000);
    dma_start <= 1'b1;
    rchk(12'h000, 32'h6702_0000);
    dma_start <= 1'b0;
    wr(12'h000, 32'hFFFF_FFFF);
    chk("write resp", {30'h0, r}, {30'h0, `CES_RESP_OKAY});
    rchk(12'h000, 32'h6702_0000);
  endtask
  task automatic t_irq;
    rchk(12'h004, 32'h0000_000F);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(12'h008, 32'h0000_000F);
    repeat (2) @(negedge aclk);
    chk("irq raised", {31'h0, irq}, 32'h0000_0001);
    wr(12'h004, 32'h0000_000F);
    repeat (2) @(negedge aclk);
    chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    rchk(12'h004, 32'h0000_0000);
    rchk(12'h00C, 32'h0000_0000);
    chk("hole resp", {30'h0, r}, {30'h0, `CES_RESP_SLVERR});
  endtask
  // A frozen cycle must neither latch an engine error nor raise an event.
  task automatic t_freeze;
    @(posedge aclk);
    clk_en <= 1'b0;
    eng_err <= {3'h2, 3'h4, 2'h1};
    eng_err_valid <= 1'b1;
    @(posedge aclk);
    clk_en <= 1'b1;
    eng_err_valid <= 1'b0;
    rchk(12'h000, 32'h6702_0000);
    rchk(12'h004, 32'h0000_0000);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    repeat (3000) @(posedge aclk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, eng_err_valid, dma_start} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, eng_err, eng_desc} = '0;
    s_axi_wstrb = 4'hF;
    clk_en = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(12'h000, 32'h0000_0000);
    rchk(12'h008, 32'h0000_0000);
    t_err();
    t_desc();
    t_start();
    t_irq();
    t_freeze();
    tally_and_finish();
  end
endmodule // ces_status_tb
